//--- rtl/cbbc_addr_if.sv
`timescale 1ns/100ps
interface cbbc_addr_if;
  logic [7:0] file;
  logic acc_sel;
  logic ext_en;
  logic [3:0] bank;
  logic [11:0] base;
  logic [11:0] addr;
  logic indexed;
  modport core (output file, output acc_sel, output ext_en, output bank, output base,
                input addr, input indexed);
  modport unit (input file, input acc_sel, input ext_en, input bank, input base,
                output addr, output indexed);
endinterface

//--- rtl/cbbc_addr_unit.sv
`timescale 1ns/100ps
`include "cbbc_params.svh"
module cbbc_addr_unit (
  cbbc_addr_if.unit aif
);
  // ==========================================================
  // Effective data address
  wire idx_hit = (~aif.acc_sel) & aif.ext_en & (aif.file <= `CBBC_IDX_LIMIT); // RL2
  wire acc_low = aif.file < `CBBC_ACC_SPLIT;
  wire [11:0] idx_addr = aif.base + {4'h0, aif.file};
  wire [11:0] bank_addr = {aif.bank, aif.file}; // RL1
  wire [11:0] acc_addr = acc_low ? {`CBBC_ACC_LO_BANK, aif.file} :
                         {`CBBC_ACC_HI_BANK, aif.file}; // RL1
  assign aif.indexed = idx_hit;
  assign aif.addr = aif.acc_sel ? bank_addr : (idx_hit ? idx_addr : acc_addr);
endmodule // cbbc_addr_unit

//--- rtl/cbbc_branch_unit.sv
`timescale 1ns/100ps
`include "cbbc_params.svh"
module cbbc_branch_unit #(
  parameter int PC_W = 21
) (
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [7:0] disp_i,
  output logic [PC_W-1:0] target_o
);
  generate
    if (PC_W < 10) begin : g_chk
      $error("cbbc_branch_unit: PC_W too small");
    end
  endgenerate
  // ==========================================================
  // Target is PC plus 2 plus twice the signed displacement
  wire [PC_W-1:0] disp_x2 = {{(PC_W-9){disp_i[7]}}, disp_i, 1'b0}; // RL4
  wire [PC_W-1:0] step = PC_W'(`CBBC_BR_STEP);
  assign target_o = pc_i + step + disp_x2; // RL6
endmodule // cbbc_branch_unit

//--- rtl/cbbc_core.sv
`timescale 1ns/100ps
`include "cbbc_params.svh"
module cbbc_core
  import cbbc_pkg::*;
#(
  parameter int PC_W = 21
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] instr_i,
  input wire logic [15:0] instr_next_i,
  output logic [20:0] pc_o,
  output logic [1:0] phase_o,
  output logic flush_o,
  input wire logic ext_set_en_i,
  input wire logic [11:0] fsr2_i,
  input wire logic [7:0] w_i,
  input wire logic [3:0] bank_select_i,
  input wire logic status_ld_i,
  input wire logic [4:0] status_d_i,
  output logic [4:0] status_o,
  output logic [11:0] mem_addr_o,
  input wire logic [7:0] mem_rdata_i,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic stack_push_o,
  output logic [20:0] top_of_stack_o,
  output logic [7:0] working_shadow_o,
  output logic [4:0] flags_shadow_o,
  output logic [3:0] bank_select_shadow_o,
  output logic watchdog_clear_o,
  input wire logic timeout_clr_i,
  input wire logic power_down_clr_i,
  output logic timeout_flag_o,
  output logic power_down_flag_o
);
  generate
    if (PC_W != 21) begin : g_chk
      $error("cbbc_core: program counter must be 21 bits");
    end
  endgenerate

  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // ==========================================================
  // Phase divider: one clock per phase
  logic [1:0] ph_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= `CBBC_PH_Q1;
    end else begin
      ph_q <= ph_q + `CBBC_PH_STEP;
    end
  end
  wire q1 = ph_q == `CBBC_PH_Q1;
  wire q2 = ph_q == `CBBC_PH_Q2;
  wire q3 = ph_q == `CBBC_PH_Q3;
  wire q4 = ph_q == `CBBC_PH_Q4;

  // ==========================================================
  // Instruction latch
  cbbc_state_t st_q;
  cbbc_state_t st_d;
  logic [15:0] ir_q;
  logic [15:0] nxt_q;
  wire st_flush = st_q == CBBC_ST_FLUSH;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ir_q <= `CBBC_OP_NOP;
      nxt_q <= `CBBC_OP_NOP;
    end else if (q1) begin
      ir_q <= st_flush ? `CBBC_OP_NOP : instr_i; // RL7
      nxt_q <= instr_next_i;
    end
  end

  // ==========================================================
  // Decode
  wire is_bit_inv = ir_q[15:12] == `CBBC_OP_BITINV;
  wire is_br_ovf = ir_q[15:8] == `CBBC_OP_BR_OVF; // RL4
  wire is_br_zero = ir_q[15:8] == `CBBC_OP_BR_ZERO; // RL8
  wire is_call = ir_q[15:9] == `CBBC_OP_CALL;
  wire call_ok = is_call && (nxt_q[15:12] == `CBBC_OP_CALL2); // RL9
  wire call_save = ir_q[`CBBC_S_BIT];
  wire is_clr_byte = ir_q[15:9] == `CBBC_OP_CLR_BYTE; // RL15
  wire is_clr_wdog = ir_q == `CBBC_OP_CLR_WDOG;
  wire [2:0] bit_sel = ir_q[`CBBC_B_HI:`CBBC_B_LO];
  wire mem_op = is_bit_inv | is_clr_byte;

  logic [4:0] status_q;
  wire ov_set = status_q[`CBBC_OV_BIT];
  wire z_set = status_q[`CBBC_Z_BIT];
  wire taken = (is_br_ovf & ov_set) | (is_br_zero & z_set); // RL5 RL8

  // ==========================================================
  // Address and branch arithmetic
  cbbc_addr_if u_aif ();
  assign u_aif.file = ir_q[7:0];
  assign u_aif.acc_sel = ir_q[`CBBC_A_BIT]; // RL1
  assign u_aif.ext_en = ext_set_en_i; // RL2
  assign u_aif.bank = bank_select_i;
  assign u_aif.base = fsr2_i;

  cbbc_addr_unit u_addr (
    .aif(u_aif)
  );

  logic [20:0] pc_q;
  wire [20:0] br_target;
  cbbc_branch_unit #(
    .PC_W(PC_W)
  ) u_branch (
    .pc_i(pc_q),
    .disp_i(ir_q[7:0]),
    .target_o(br_target)
  );

  wire [20:0] call_target = {nxt_q[11:0], ir_q[7:0], 1'b0}; // RL13
  wire [20:0] seq_pc = pc_q + `CBBC_BR_STEP;
  wire [20:0] ret_pc = pc_q + `CBBC_CALL_STEP; // RL10
  wire [20:0] pc_d = st_flush ? pc_q :
                     call_ok ? call_target :
                     taken ? br_target : seq_pc; // RL6
  wire redirect = call_ok | taken;

  // ==========================================================
  // Data memory path
  logic [11:0] addr_q;
  logic [7:0] wdata_q;
  wire [7:0] bit_mask = `CBBC_BIT_ONE << bit_sel;
  wire [7:0] wdata_d = is_clr_byte ? `CBBC_BYTE_ZERO : (mem_rdata_i ^ bit_mask); // RL3 RL15
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= `CBBC_ADDR_RST;
      wdata_q <= `CBBC_BYTE_ZERO;
    end else begin
      if (q2) begin
        addr_q <= u_aif.addr;
      end
      if (q3 && mem_op) begin
        wdata_q <= wdata_d;
      end
    end
  end
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = wdata_q;
  assign mem_we_o = q4 & mem_op; // RL3 RL15

  // ==========================================================
  // Program counter and sequencing
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= `CBBC_PC_RST;
    end else if (q4) begin
      pc_q <= pc_d; // RL14
    end
  end

  always_comb begin
    case (st_q)
      CBBC_ST_EXEC: st_d = redirect ? CBBC_ST_FLUSH : CBBC_ST_EXEC; // RL7 RL14
      CBBC_ST_FLUSH: st_d = CBBC_ST_EXEC;
      default: st_d = CBBC_ST_EXEC;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= CBBC_ST_EXEC;
    end else if (q4) begin
      st_q <= st_d;
    end
  end
  assign pc_o = pc_q;
  assign phase_o = ph_q;
  assign flush_o = st_flush;

  // ==========================================================
  // Return stack push and shadow save
  logic [20:0] stack_top_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_q <= `CBBC_PC_RST;
    end else if (q2 && call_ok) begin
      stack_top_q <= ret_pc; // RL10
    end
  end
  assign top_of_stack_o = stack_top_q;
  assign stack_push_o = q3 & call_ok; // RL14

  logic [7:0] wsh_q;
  logic [4:0] ss_q;
  logic [3:0] bs_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wsh_q <= `CBBC_W_RST;
      ss_q <= `CBBC_STAT_RST;
      bs_q <= `CBBC_BANK_RST;
    end else if (q3 && call_ok && call_save) begin // RL12
      wsh_q <= w_i; // RL11
      ss_q <= status_q;
      bs_q <= bank_select_i;
    end
  end
  assign working_shadow_o = wsh_q;
  assign flags_shadow_o = ss_q;
  assign bank_select_shadow_o = bs_q;

  // ==========================================================
  // Status flags: outside load, and clear byte sets the zero flag
  wire clr_byte_wr = q4 & is_clr_byte;
  wire [4:0] status_base = status_ld_i ? status_d_i : status_q;
  wire [4:0] status_d = clr_byte_wr ? (status_base | `CBBC_Z_MASK) : status_base; // RL15
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `CBBC_STAT_RST;
    end else begin
      status_q <= status_d;
    end
  end
  assign status_o = status_q;

  // ==========================================================
  // Watchdog clear; set wins over an outside clear
  wire wdog_hit = q3 & is_clr_wdog;
  logic tout_q;
  logic pdown_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tout_q <= `CBBC_FLAG_RST;
      pdown_q <= `CBBC_FLAG_RST;
    end else begin
      tout_q <= wdog_hit | (tout_q & ~timeout_clr_i); // RL17
      pdown_q <= wdog_hit | (pdown_q & ~power_down_clr_i); // RL17
    end
  end
  assign watchdog_clear_o = wdog_hit; // RL16
  assign timeout_flag_o = tout_q;
  assign power_down_flag_o = pdown_q;

  // ==========================================================
  // Checks
  wire [20:0] chk_target = pc_q + `CBBC_BR_STEP + {{12{ir_q[7]}}, ir_q[7:0], 1'b0};

  property p_bank_addr;
    @(posedge clk_i) disable iff (!rst_n)
    (q2 && ir_q[`CBBC_A_BIT]) |=> (mem_addr_o == {$past(bank_select_i), $past(ir_q[7:0])});
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("bank select address wrong"); // RL1

  property p_index_addr;
    @(posedge clk_i) disable iff (!rst_n)
    (q2 && !ir_q[`CBBC_A_BIT] && ext_set_en_i && ir_q[7:0] <= `CBBC_IDX_LIMIT)
      |=> (mem_addr_o == $past(fsr2_i) + {4'h0, $past(ir_q[7:0])});
  endproperty
  a_index_addr: assert property (p_index_addr) else $error("indexed address wrong"); // RL2

  property p_bit_invert;
    @(posedge clk_i) disable iff (!rst_n)
    (q3 && is_bit_inv && !status_ld_i)
      |=> (mem_wdata_o == ($past(mem_rdata_i) ^ (`CBBC_BIT_ONE << $past(bit_sel))))
          && mem_we_o && $stable(status_o);
  endproperty
  a_bit_invert: assert property (p_bit_invert) else $error("bit invert wrong"); // RL3

  sequence s_taken;
    q4 && st_q == CBBC_ST_EXEC && taken;
  endsequence
  sequence s_flush_cycle;
    (st_q == CBBC_ST_FLUSH)[*4] ##1 (st_q == CBBC_ST_EXEC);
  endsequence

  property p_branch_target;
    @(posedge clk_i) disable iff (!rst_n)
    s_taken |=> (pc_o == $past(chk_target));
  endproperty
  a_branch_target: assert property (p_branch_target) else $error("branch target wrong"); // RL6

  property p_branch_flush;
    @(posedge clk_i) disable iff (!rst_n)
    s_taken |=> s_flush_cycle;
  endproperty
  a_branch_flush: assert property (p_branch_flush) else $error("taken branch no flush"); // RL7

  property p_ovf_fall;
    @(posedge clk_i) disable iff (!rst_n)
    (q4 && is_br_ovf && !ov_set) |=> (pc_o == $past(pc_o) + `CBBC_BR_STEP) && !flush_o;
  endproperty
  a_ovf_fall: assert property (p_ovf_fall) else $error("untaken overflow branch"); // RL5

  property p_zero_flags;
    @(posedge clk_i) disable iff (!rst_n)
    (q4 && is_br_zero && !status_ld_i) |=> $stable(status_o);
  endproperty
  a_zero_flags: assert property (p_zero_flags) else $error("zero branch changed flags"); // RL8

  property p_push_value;
    @(posedge clk_i) disable iff (!rst_n)
    stack_push_o |-> (top_of_stack_o == pc_o + `CBBC_CALL_STEP) ##1 q4 ##1 (pc_o == $past(call_target));
  endproperty
  a_push_value: assert property (p_push_value) else $error("call push or target wrong"); // RL10 RL13 RL14

  property p_shadow_save;
    @(posedge clk_i) disable iff (!rst_n)
    (q3 && call_ok && call_save) |=> (working_shadow_o == $past(w_i))
      && (bank_select_shadow_o == $past(bank_select_i)) && (flags_shadow_o == $past(status_o));
  endproperty
  a_shadow_save: assert property (p_shadow_save) else $error("shadow save wrong"); // RL11

  property p_shadow_keep;
    @(posedge clk_i) disable iff (!rst_n)
    !(q3 && call_ok && call_save) |=> $stable(working_shadow_o) && $stable(flags_shadow_o)
      && $stable(bank_select_shadow_o);
  endproperty
  a_shadow_keep: assert property (p_shadow_keep) else $error("shadow changed"); // RL12

  property p_clear_byte;
    @(posedge clk_i) disable iff (!rst_n)
    (q4 && is_clr_byte) |-> mem_we_o && (mem_wdata_o == `CBBC_BYTE_ZERO) ##1 status_o[`CBBC_Z_BIT];
  endproperty
  a_clear_byte: assert property (p_clear_byte) else $error("clear byte wrong"); // RL15

  property p_wdog_pulse;
    @(posedge clk_i) disable iff (!rst_n)
    watchdog_clear_o |-> q3 && is_clr_wdog ##1 !watchdog_clear_o;
  endproperty
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("watchdog clear pulse wrong"); // RL16

  property p_wdog_flags;
    @(posedge clk_i) disable iff (!rst_n)
    (watchdog_clear_o && !status_ld_i) |=> timeout_flag_o && power_down_flag_o
      && $stable(status_o);
  endproperty
  a_wdog_flags: assert property (p_wdog_flags) else $error("watchdog flags wrong"); // RL17
endmodule // cbbc_core

//--- rtl/cbbc_params.svh
// Functional notes
// RL1: Access-select 0 uses the access bank; 1 takes upper address from bank select.
// RL2: Access-select 0 with extended set: file operand up to 95 is indexed offset.
// RL3: Bit invert flips only the chosen bit, writes back, leaves flags alone.
// RL4: Branch on overflow has fixed upper byte; low byte is signed displacement.
// RL5: Branch on overflow jumps only when overflow is 1, else falls through.
// RL6: Taken branch target is branch address plus 2 plus twice displacement.
// RL7: Taken branch takes two cycles with a flush; untaken takes one.
// RL8: Branch on zero jumps only when zero is 1; flags unchanged.
// RL9: Call is two words: opcode, save bit, k low; then 1111 and k high.
// RL10: Call pushes its own address plus 4 as the new top of stack.
// RL11: Save bit 1 copies working, flags and bank select into shadows.
// RL12: Save bit 0 leaves all three shadow registers unchanged.
// RL13: Call loads its 20-bit target into program counter bits 20 to 1.
// RL14: Call takes two cycles: push in first, counter written in Q4, then flush.
// RL15: Clear byte writes zero into addressed byte and sets zero flag, one cycle.
// RL16: Watchdog clear resets watchdog counter and postscaler in one cycle.
// RL17: Watchdog clear sets timeout and power-down flags only.
`ifndef CBBC_PARAMS_SVH
`define CBBC_PARAMS_SVH

// ==========================================================
// Opcode patterns and field positions
`define CBBC_OP_BITINV 4'h7
`define CBBC_OP_BR_OVF 8'hE4
`define CBBC_OP_BR_ZERO 8'hE0
`define CBBC_OP_CALL 7'h76
`define CBBC_OP_CALL2 4'hF
`define CBBC_OP_CLR_BYTE 7'h35
`define CBBC_OP_CLR_WDOG 16'h0004
`define CBBC_OP_NOP 16'h0000
`define CBBC_A_BIT 8
`define CBBC_S_BIT 8
`define CBBC_B_HI 11
`define CBBC_B_LO 9

// ==========================================================
// Addressing
`define CBBC_IDX_LIMIT 8'h5F
`define CBBC_ACC_SPLIT 8'h60
`define CBBC_ACC_LO_BANK 4'h0
`define CBBC_ACC_HI_BANK 4'hF

// ==========================================================
// Arithmetic steps, masks and reset values
`define CBBC_BR_STEP 21'h000002
`define CBBC_CALL_STEP 21'h000004
`define CBBC_PC_RST 21'h000000
`define CBBC_STAT_RST 5'h00
`define CBBC_Z_BIT 2
`define CBBC_OV_BIT 3
`define CBBC_Z_MASK 5'h04
`define CBBC_BYTE_ZERO 8'h00
`define CBBC_BIT_ONE 8'h01
`define CBBC_W_RST 8'h00
`define CBBC_BANK_RST 4'h0
`define CBBC_ADDR_RST 12'h000
`define CBBC_FLAG_RST 1'b1

// ==========================================================
// Instruction cycle phases
`define CBBC_PH_Q1 2'h0
`define CBBC_PH_Q2 2'h1
`define CBBC_PH_Q3 2'h2
`define CBBC_PH_Q4 2'h3
`define CBBC_PH_STEP 2'h1

`endif

//--- rtl/cbbc_pkg.sv
package cbbc_pkg;
  typedef enum logic [1:0] {
    CBBC_ST_EXEC = 2'b01,
    CBBC_ST_FLUSH = 2'b10
  } cbbc_state_t;
  typedef logic [4:0] cbbc_status_t;
endpackage

//--- tb/cbbc_core_tb_top.sv
`timescale 1ns/100ps
module cbbc_core_tb_top;
  // ==========================================================
  // Design ports and bench state
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [15:0] instr_next_i = 16'h0000;
  logic ext_set_en_i = 1'b0;
  logic [11:0] fsr2_i = 12'h000;
  logic [7:0] w_i = 8'h00;
  logic [3:0] bank_select_i = 4'h0;
  logic status_ld_i = 1'b0;
  logic [4:0] status_d_i = 5'h00;
  logic [7:0] mem_rdata_i = 8'h00;
  logic timeout_clr_i = 1'b0;
  logic power_down_clr_i = 1'b0;
  logic [20:0] pc_o;
  logic [1:0] phase_o;
  logic flush_o;
  logic [4:0] status_o;
  logic [11:0] mem_addr_o;
  logic [7:0] mem_wdata_o;
  logic mem_we_o;
  logic stack_push_o;
  logic [20:0] top_of_stack_o;
  logic [7:0] working_shadow_o;
  logic [4:0] flags_shadow_o;
  logic [3:0] bank_select_shadow_o;
  logic watchdog_clear_o;
  logic timeout_flag_o;
  logic power_down_flag_o;
  int n_errors = 0;
  int checks = 0;
  int seed = 65579;

  always #20 clk_i = ~clk_i;

  cbbc_core #(.PC_W(21)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .instr_next_i(instr_next_i),
    .pc_o(pc_o), .phase_o(phase_o), .flush_o(flush_o), .ext_set_en_i(ext_set_en_i),
    .fsr2_i(fsr2_i), .w_i(w_i), .bank_select_i(bank_select_i), .status_ld_i(status_ld_i),
    .status_d_i(status_d_i), .status_o(status_o), .mem_addr_o(mem_addr_o),
    .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
    .stack_push_o(stack_push_o), .top_of_stack_o(top_of_stack_o),
    .working_shadow_o(working_shadow_o), .flags_shadow_o(flags_shadow_o),
    .bank_select_shadow_o(bank_select_shadow_o), .watchdog_clear_o(watchdog_clear_o),
    .timeout_clr_i(timeout_clr_i), .power_down_clr_i(power_down_clr_i),
    .timeout_flag_o(timeout_flag_o), .power_down_flag_o(power_down_flag_o)
  );

  // ==========================================================
  // Reporting
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // ==========================================================
  // Expectations and drivers
  function automatic logic [11:0] exp_addr(input logic [15:0] ins);
    if (ins[8]) return {bank_select_i, ins[7:0]};
    if (ext_set_en_i && ins[7:0] <= 8'h5F) return fsr2_i + {4'h0, ins[7:0]};
    return {(ins[7:0] < 8'h60) ? 4'h0 : 4'hF, ins[7:0]};
  endfunction

  // Returns at a falling edge inside an executing Q1
  task automatic wait_q1();
    int n;
    for (n = 0; n < 40; n++) begin
      if (phase_o === 2'h0 && flush_o === 1'b0) break;
      @(negedge clk_i);
    end
    if (n == 40) begin
      n_errors++;
      $display("ERROR t=%0t no instruction slot", $time);
      conclude();
    end
  endtask

  // Loaded during a filler cycle so no instruction sees it mid-flight
  task automatic set_status(input logic [4:0] v);
    status_ld_i = 1'b1;
    status_d_i = v;
    @(negedge clk_i);
    status_ld_i = 1'b0;
    chk(status_o, v, "status load");
  endtask

  task automatic exec(input logic [15:0] ins, input logic [15:0] nxt, input logic [7:0] rd);
    logic [20:0] pc0;
    logic [20:0] pc_x;
    logic [4:0] st0;
    logic [7:0] ws0;
    logic [4:0] fs0;
    logic [3:0] bs0;
    logic tf0;
    logic pf0;
    logic mem_op;
    logic call_op;
    logic wdog_op;
    logic taken;
    logic save;
    wait_q1();
    w_i = 8'($random(seed));
    bank_select_i = 4'($random(seed));
    fsr2_i = 12'($random(seed));
    instr_i = ins;
    instr_next_i = nxt;
    mem_rdata_i = rd;
    pc0 = pc_o;
    st0 = status_o;
    ws0 = working_shadow_o;
    fs0 = flags_shadow_o;
    bs0 = bank_select_shadow_o;
    tf0 = timeout_flag_o;
    pf0 = power_down_flag_o;
    mem_op = ins[15:12] == 4'h7 || ins[15:9] == 7'h35;
    call_op = ins[15:9] == 7'h76 && nxt[15:12] == 4'hF;
    wdog_op = ins == 16'h0004;
    taken = (ins[15:8] == 8'hE4 && st0[3]) || (ins[15:8] == 8'hE0 && st0[2]);
    save = call_op && ins[8];
    pc_x = call_op ? {nxt[11:0], ins[7:0], 1'b0} : pc0 + 21'h000002;
    if (taken) pc_x = pc0 + 21'h000002 + {{12{ins[7]}}, ins[7:0], 1'b0};
    repeat (2) @(negedge clk_i);
    chk(stack_push_o, call_op, "push");
    chk(watchdog_clear_o, wdog_op, "watchdog clear");
    if (call_op) chk(top_of_stack_o, pc0 + 21'h000004, "top of stack");
    if (mem_op) chk(mem_addr_o, exp_addr(ins), "address");
    @(negedge clk_i);
    instr_i = 16'h0000;
    chk(mem_we_o, mem_op, "write strobe");
    if (mem_op) chk(mem_wdata_o, ins[12] ? rd ^ (8'h01 << ins[11:9]) : 8'h00, "wdata");
    chk(status_o, st0, "flags in Q4");
    @(negedge clk_i);
    chk(pc_o, pc_x, "program counter");
    chk(flush_o, taken || call_op, "flush");
    chk(status_o, ins[15:9] == 7'h35 ? st0 | 5'h04 : st0, "flags after");
    chk(working_shadow_o, save ? w_i : ws0, "w shadow");
    chk(flags_shadow_o, save ? st0 : fs0, "status shadow");
    chk(bank_select_shadow_o, save ? bank_select_i : bs0, "bank shadow");
    chk(timeout_flag_o, wdog_op | tf0, "timeout flag");
    chk(power_down_flag_o, wdog_op | pf0, "power-down flag");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] corners;
    logic [4:0] st;
    logic [19:0] k;
    logic [7:0] f;
    logic a;
    corners = {8'hFF, 8'h00, 8'h60, 8'h5F};
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk(pc_o, 21'h000000, "reset counter");
    chk(timeout_flag_o, 1'b1, "reset timeout flag");
    chk(power_down_flag_o, 1'b1, "reset power-down flag");
    repeat (3) @(negedge clk_i);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      set_status(5'($random(seed)));
      f = (i < 4) ? corners[8*i +: 8] : 8'($random(seed));
      a = (i < 8) ? 1'b0 : 1'($random(seed));
      ext_set_en_i = (i < 4) ? 1'b1 : 1'($random(seed));
      exec(i[0] ? {7'h35, a, f} : {4'h7, 3'($random(seed)), a, f}, 16'h0000,
           8'($random(seed)));
    end
    $display("test byte ops done");
    for (int i = 0; i < 16; i++) begin
      st = 5'($random(seed));
      st[3] = i[1];
      st[2] = ~i[1];
      set_status(st);
      exec({i[2] ? 8'hE4 : 8'hE0, (i < 8) ? (i[0] ? 8'h80 : 8'h7F) : 8'($random(seed))},
           16'h0000, 8'h00);
    end
    $display("test branches done");
    for (int i = 0; i < 6; i++) begin
      set_status(5'($random(seed)));
      k = 20'($random(seed));
      exec({7'h76, i[0], k[7:0]}, {4'hF, k[19:8]}, 8'h00);
    end
    $display("test calls done");
    for (int i = 0; i < 2; i++) begin
      timeout_clr_i = 1'b1;
      power_down_clr_i = i[0];
      @(negedge clk_i);
      timeout_clr_i = 1'b0;
      power_down_clr_i = 1'b0;
      chk(timeout_flag_o, 1'b0, "timeout cleared");
      exec(16'h0004, 16'h0000, 8'h00);
    end
    $display("test watchdog clear done");
    conclude();
  end
endmodule  // cbbc_core_tb_top
